//--- design/tbps_sequencer.v
// tbps_sequencer.v: enable decode, automatic ordering, soft-start and power-good
// for three step-down channels, with an AXI4-Lite register slave.
// assumes all pin inputs are asynchronous levels from comparators; one clock.
//
// How it works
// R01 - channel runs once its enable is high
// R02 - enable low stops channel, low quiescent state
// R03 - input lockout disables all; rising/falling levels
// R04 - host drives enables only by open drain
// R05 - each channel soft-starts 2.4 ms after turn-on
// R06 - auto sequencing: mode high/low, enable1 or 2
// R07 - floating mode: each enable drives own channel
// R08 - enable3 starts power-up, lowering starts power-down
// R09 - low, both high: up 1-2-3, down 3-2-1
// R10 - low, en2 only: up 2-1-3, down 3-1-2
// R11 - low, en1 only: up 2-3-1, down 1-3-2
// R12 - high, both high: up 1-3-2, down 2-3-1
// R13 - high, en2 only: up 3-1-2, down 2-1-3
// R14 - high, en1 only: up 3-2-1, down 1-2-3
// R15 - ramp level one steps second, two third
// R16 - power-good monitor enabled after soft-start
// R17 - power-good after regulation plus delay ramp
// R18 - bias regulator on at lower enable level
// R19 - power-good low in soft-start, lockout, fault, enable low
// R20 - auto with both enables low: all off
// R21 - mode decoded low, high, float; float independent
`timescale 1ns/10ps
`include "tbps_defs.vh"

module tbps_sequencer #(
  parameter SS_CYCLES = `TBPS_SS_CYCLES
) (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // pins, asynchronous
  input  wire        chan1_enable_in_i,
  input  wire        chan2_enable_in_i,
  input  wire        chan3_enable_in_i,
  input  wire [2:0]  bias_level_i,
  input  wire        mode_high_i,
  input  wire        mode_low_i,
  input  wire        lockout_rise_i,
  input  wire        lockout_fall_i,
  input  wire        thermal_fault_i,
  input  wire        seq_level1_i,
  input  wire        seq_level2_i,
  input  wire        pg_level_i,
  input  wire [2:0]  in_regulation_i,
  // outputs
  output reg  [2:0]  chan_run_o,
  output reg  [2:0]  chan_soft_start_o,
  output reg  [2:0]  pg_monitor_en_o,
  output reg         internal_bias_rail_o,
  output reg         seq_ramp_reset_o,
  output reg         pg_ramp_reset_o,
  output reg         power_ok_o,
  // AXI4-Lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam ST_OFF  = 2'h0;
  localparam ST_UP   = 2'h1;
  localparam ST_ON   = 2'h2;
  localparam ST_DOWN = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every pin input
  localparam NSYNC = 17;
  wire [NSYNC-1:0] pin_raw = {chan1_enable_in_i, chan2_enable_in_i, chan3_enable_in_i,
                              bias_level_i, mode_high_i, mode_low_i, lockout_rise_i,
                              lockout_fall_i, thermal_fault_i, seq_level1_i, seq_level2_i,
                              pg_level_i, in_regulation_i};
  reg  [NSYNC-1:0] sync_a;
  reg  [NSYNC-1:0] sync_b;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire       en1    = sync_b[16];
  wire       en2    = sync_b[15];
  wire       en3    = sync_b[14];
  wire [2:0] bias_s = sync_b[13:11];
  wire       m_hi   = sync_b[10];
  wire       m_lo   = sync_b[9];
  wire       lk_r   = sync_b[8];
  wire       lk_f   = sync_b[7];
  wire       therm  = sync_b[6];
  wire       lvl1   = sync_b[5];
  wire       lvl2   = sync_b[4];
  wire       pglvl  = sync_b[3];
  wire [2:0] inreg  = sync_b[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // lockout with hysteresis: set on falling level, cleared on rising level
  reg lockout;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i)
      lockout <= 1'b1;
    else if (lk_f)
      lockout <= 1'b1;                       // [R03]
    else if (lk_r)
      lockout <= 1'b0;                       // [R03]
  end

  // mode decode: neither comparator set means the pin floats
  reg [1:0] mode;
  always @* begin
    if (m_lo)
      mode = `TBPS_MODE_LOW;                 // [R21]
    else if (m_hi)
      mode = `TBPS_MODE_HIGH;                // [R21]
    else
      mode = `TBPS_MODE_FLOAT;               // [R21]
  end
  wire auto_mode = (mode != `TBPS_MODE_FLOAT) && (en1 || en2); // [R06] [R20]

  ////////////////////////////////////////////////////////////////////////////
  // power-up order as three channel indexes; power-down is the reverse
  reg [1:0] ord0;
  reg [1:0] ord1;
  reg [1:0] ord2;
  always @* begin
    ord0 = 2'h0;
    ord1 = 2'h1;
    ord2 = 2'h2;
    case ({mode == `TBPS_MODE_HIGH, en1, en2})
      3'b011: begin ord0 = 2'h0; ord1 = 2'h1; ord2 = 2'h2; end // [R09]
      3'b001: begin ord0 = 2'h1; ord1 = 2'h0; ord2 = 2'h2; end // [R10]
      3'b010: begin ord0 = 2'h1; ord1 = 2'h2; ord2 = 2'h0; end // [R11]
      3'b111: begin ord0 = 2'h0; ord1 = 2'h2; ord2 = 2'h1; end // [R12]
      3'b101: begin ord0 = 2'h2; ord1 = 2'h0; ord2 = 2'h1; end // [R13]
      3'b110: begin ord0 = 2'h2; ord1 = 2'h1; ord2 = 2'h0; end // [R14]
      default: begin ord0 = 2'h0; ord1 = 2'h1; ord2 = 2'h2; end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // automatic sequencer: step counts channels on, ramp levels advance it
  reg [1:0] state;
  reg [1:0] step;
  reg [1:0] o0;
  reg [1:0] o1;
  reg [1:0] o2;
  reg       ramp_rst;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state    <= ST_OFF;
      step     <= 2'h0;
      o0       <= 2'h0;
      o1       <= 2'h1;
      o2       <= 2'h2;
      ramp_rst <= 1'b1;
    end else if (lockout || therm || !auto_mode) begin
      state    <= ST_OFF;                    // [R03] [R20]
      step     <= 2'h0;
      ramp_rst <= 1'b1;
    end else begin
      case (state)
        ST_OFF: if (en3) begin               // [R08]
          state    <= ST_UP;
          step     <= 2'h1;
          o0       <= ord0;
          o1       <= ord1;
          o2       <= ord2;
          ramp_rst <= 1'b0;
        end
        ST_UP: begin
          if (!en3) begin                    // [R08]
            state    <= ST_DOWN;
            ramp_rst <= 1'b1;
          end else if (step == 2'h1 && lvl1)
            step <= 2'h2;                    // [R15]
          else if (step == 2'h2 && lvl2) begin
            step     <= 2'h3;                // [R15]
            state    <= ST_ON;
            ramp_rst <= 1'b1;
          end
        end
        ST_ON: if (!en3) begin               // [R08]
          state    <= ST_DOWN;
          ramp_rst <= 1'b1;
        end
        ST_DOWN: begin
          if (ramp_rst) begin
            if (!lvl1)
              ramp_rst <= 1'b0;              // hold discharge until level reads low
          end
          else if (en3) begin
            state <= ST_UP;
            step  <= (step == 2'h3) ? 2'h2 : step;
          end else if (step == 2'h3) begin
            step     <= 2'h2;                // last channel off at once
            ramp_rst <= 1'b1;
          end else if (step == 2'h2 && lvl1) begin
            step     <= 2'h1;                // [R15]
            ramp_rst <= 1'b1;
          end else if (step == 2'h1 && lvl1) begin
            step  <= 2'h0;                   // [R15]
            state <= ST_OFF;
            ramp_rst <= 1'b1;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // channel demand: sequenced position or own enable
  reg [2:0] want;
  integer k;
  always @* begin
    want = 3'h0;
    for (k = 0; k < 3; k = k + 1) begin
      if (auto_mode)
        want[k] = (step > 2'h0 && o0 == k[1:0]) || (step > 2'h1 && o1 == k[1:0]) ||
                  (step > 2'h2 && o2 == k[1:0]);
      else if (mode == `TBPS_MODE_FLOAT)
        want[k] = (k == 0) ? en1 : ((k == 1) ? en2 : en3);  // [R07] [R01]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel run, soft-start counter and power-good monitor enable
  reg [31:0] ctrl;                           // control register, written over the bus
  reg  [2:0] ss_done;
  wire       global_off = lockout || therm;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
      reg [19:0] ss_cnt;
      always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          chan_run_o[gi]        <= 1'b0;
          chan_soft_start_o[gi] <= 1'b0;
          pg_monitor_en_o[gi]   <= 1'b0;
          ss_done[gi]           <= 1'b0;
          ss_cnt                <= 20'h00000;
        end else if (global_off || !want[gi]) begin
          chan_run_o[gi]        <= 1'b0;     // [R02] [R03]
          chan_soft_start_o[gi] <= 1'b0;
          pg_monitor_en_o[gi]   <= 1'b0;
          ss_done[gi]           <= 1'b0;
          ss_cnt                <= 20'h00000;
        end else begin
          chan_run_o[gi] <= 1'b1;            // [R01]
          if (ss_cnt < SS_CYCLES[19:0]) begin
            ss_cnt                <= ss_cnt + 20'h00001;
            chan_soft_start_o[gi] <= 1'b1;   // [R05]
          end else begin
            chan_soft_start_o[gi] <= 1'b0;
            ss_done[gi]           <= 1'b1;
            pg_monitor_en_o[gi]   <= ctrl[`TBPS_CTRL_PGMON_EN]; // [R16]
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bias rail, ramp discharges and power-good output
  wire all_en  = en1 && en2 && en3;
  wire seq_ok  = auto_mode ? (state == ST_ON) : 1'b1;
  wire pg_cond = !global_off && all_en && seq_ok && (&ss_done) &&
                 (&pg_monitor_en_o) && (&inreg);                // [R19]
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      internal_bias_rail_o <= 1'b0;
      seq_ramp_reset_o     <= 1'b1;
      pg_ramp_reset_o      <= 1'b1;
      power_ok_o           <= 1'b0;
    end else begin
      internal_bias_rail_o <= |bias_s;                          // [R18]
      seq_ramp_reset_o     <= ramp_rst;
      pg_ramp_reset_o      <= !pg_cond;                         // [R17]
      power_ok_o           <= pg_cond && pglvl;                 // [R17] [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: write once address and data both held
  reg        aw_got;
  reg        w_got;
  reg [11:0] aw_q;
  reg [31:0] w_q;
  reg [3:0]  ws_q;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl          <= `TBPS_CTRL_RST;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_q          <= 12'h000;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TBPS_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_got && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_got <= 1'b1;
        aw_q   <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_got <= 1'b1;
        w_q   <= s_axi_wdata;
        ws_q  <= s_axi_wstrb;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_q[11:2] == `TBPS_REG_CTRL >> 2) begin
          if (ws_q[0])
            ctrl[7:0] <= w_q[7:0];
          s_axi_bresp <= `TBPS_RESP_OKAY;
        end else if (aw_q[11:2] == `TBPS_REG_STATUS >> 2 ||
                     aw_q[11:2] == `TBPS_REG_PINS >> 2)
          s_axi_bresp <= `TBPS_RESP_OKAY;    // read-only, write ignored
        else
          s_axi_bresp <= `TBPS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: data two edges after address is offered
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TBPS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `TBPS_RESP_OKAY;
        case (s_axi_araddr[11:2])
          `TBPS_REG_CTRL >> 2:   s_axi_rdata <= {24'h000000, ctrl[7:0]};
          `TBPS_REG_STATUS >> 2: s_axi_rdata <= {16'h0000, power_ok_o, lockout, state,
                                                 step, 1'b0, pg_monitor_en_o,
                                                 chan_soft_start_o, chan_run_o};
          `TBPS_REG_PINS >> 2:   s_axi_rdata <= {24'h000000, mode, therm, en1, en2, en3,
                                                 auto_mode, 1'b0};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TBPS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tbps_sequencer

//--- design/tbps_defs.vh
// tbps_defs.vh: constants for the triple buck power sequencer
// assumes a 125 MHz system clock; included by the sequencer top
`ifndef TBPS_DEFS_VH
`define TBPS_DEFS_VH

// register byte offsets
`define TBPS_REG_CTRL      12'h000
`define TBPS_REG_STATUS    12'h004
`define TBPS_REG_PINS      12'h008

// control register fields and reset value
`define TBPS_CTRL_PGMON_EN 0
`define TBPS_CTRL_RST      32'h0000_0001

// mode input encodings
`define TBPS_MODE_LOW      2'h0
`define TBPS_MODE_HIGH     2'h1
`define TBPS_MODE_FLOAT    2'h2

// soft-start time in microseconds and in clock cycles
`define TBPS_SS_TIME_US    2400
`define TBPS_CLK_MHZ       125
`define TBPS_SS_CYCLES     (`TBPS_SS_TIME_US * `TBPS_CLK_MHZ)

// AXI responses
`define TBPS_RESP_OKAY     2'h0
`define TBPS_RESP_SLVERR   2'h2

`endif

//--- testbench/tbps_seq_props.sv
// checker: port relations of the sequencer top
// assumes two-flop pin sync plus one output register stage
`timescale 1ns/10ps
module tbps_seq_props (
  input wire       sys_clk_i,
  input wire       sys_rst_i,
  input wire       chan1_enable_in_i,
  input wire       chan2_enable_in_i,
  input wire       chan3_enable_in_i,
  input wire       mode_high_i,
  input wire       mode_low_i,
  input wire       lockout_fall_i,
  input wire       thermal_fault_i,
  input wire       pg_level_i,
  input wire [2:0] in_regulation_i,
  input wire [2:0] chan_run_o,
  input wire [2:0] chan_soft_start_o,
  input wire [2:0] pg_monitor_en_o,
  input wire       power_ok_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // a pin held five edges outlasts sync and register latency
  a_lockout_off: assert property (lockout_fall_i [*5] |-> chan_run_o == 3'h0)
    else $error("channel runs in lockout");
  a_pok_thermal: assert property (thermal_fault_i [*5] |-> !power_ok_o)
    else $error("power ok in thermal fault");
  a_pok_enables: assert property (!(chan1_enable_in_i && chan2_enable_in_i
    && chan3_enable_in_i) [*5] |-> !power_ok_o)
    else $error("power ok with an enable low");
  a_pok_delay: assert property (!pg_level_i [*5] |-> !power_ok_o)
    else $error("power ok before delay ramp");
  a_pok_regul: assert property ((in_regulation_i != 3'h7) [*5] |-> !power_ok_o)
    else $error("power ok out of regulation");
  a_pok_gated: assert property (power_ok_o |-> chan_soft_start_o == 3'h0
    && pg_monitor_en_o == 3'h7)
    else $error("power ok in soft start");
  a_mon_after_ss: assert property ($rose(pg_monitor_en_o[1]) |->
    !chan_soft_start_o[1] && chan_run_o[1])
    else $error("monitor on during soft start");
  a_ss_at_start: assert property ($rose(chan_run_o[0]) |-> ##[0:1] chan_soft_start_o[0])
    else $error("no soft start at turn on");
  a_float_off: assert property ((!mode_high_i && !mode_low_i && !chan2_enable_in_i) [*5]
    |-> !chan_run_o[1])
    else $error("channel two runs while disabled");
  a_reserved_off: assert property (((mode_low_i || mode_high_i) && !chan1_enable_in_i
    && !chan2_enable_in_i) [*5] |-> chan_run_o == 3'h0)
    else $error("reserved combination runs");
  // main scenarios reached
  c_pok: cover property ($rose(power_ok_o));
  c_third: cover property ($rose(chan_run_o[2]));
  c_mon: cover property (pg_monitor_en_o == 3'h7);
endmodule // tbps_seq_props

bind tbps_sequencer tbps_seq_props u_props (.sys_clk_i, .sys_rst_i, .chan1_enable_in_i,
  .chan2_enable_in_i, .chan3_enable_in_i, .mode_high_i, .mode_low_i, .lockout_fall_i,
  .thermal_fault_i, .pg_level_i, .in_regulation_i, .chan_run_o, .chan_soft_start_o,
  .pg_monitor_en_o, .power_ok_o);

//--- testbench/tbps_host_model.sv
// partner: host open-drain enables and the two timing-capacitor ramps
// assumes ramp resets come from the sequencer outputs
`timescale 1ns/10ps
module tbps_host_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [2:0] pull_low_i,
  input  wire [7:0] ramp_step_i,
  input  wire       seq_ramp_reset_i,
  input  wire       pg_ramp_reset_i,
  output wire [2:0] enable_o,
  output wire       seq_level1_o,
  output wire       seq_level2_o,
  output wire       pg_level_o
);
  int seq_cnt = 0;
  int pg_cnt = 0;
  // released lines float up to the internal pull-up
  assign enable_o = ~pull_low_i;
  // ramps charge while not discharged
  always @(posedge clk_i) begin
    seq_cnt <= (rst_i || seq_ramp_reset_i) ? 0 : seq_cnt + 1;
    pg_cnt <= (rst_i || pg_ramp_reset_i) ? 0 : pg_cnt + 1;
  end
  assign seq_level1_o = seq_cnt >= ramp_step_i;
  assign seq_level2_o = seq_cnt >= 2 * ramp_step_i;
  assign pg_level_o = pg_cnt >= ramp_step_i;
endmodule // tbps_host_model

//--- testbench/tb_triple_buck_power_sequencer.sv
// testbench: registers, independent control, power good and auto order
// assumes the sequencer with a shortened soft-start count
`timescale 1ns/10ps
`include "tbps_defs.vh"
module tb_triple_buck_power_sequencer;
  localparam int SS = 20;
  logic sys_clk_i = 0, sys_rst_i = 1, mode_high_i = 0, mode_low_i = 0;
  logic lockout_rise_i = 1, lockout_fall_i = 0, thermal_fault_i = 0;
  logic [2:0] bias_level_i = 3'h0, in_regulation_i = 3'h7, pull_low = 3'h7;
  logic [7:0] ramp = 8'h06;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  wire chan1_enable_in_i, chan2_enable_in_i, chan3_enable_in_i;
  wire seq_level1_i, seq_level2_i, pg_level_i, power_ok_o;
  wire internal_bias_rail_o, seq_ramp_reset_o, pg_ramp_reset_o;
  wire [2:0] chan_run_o, chan_soft_start_o, pg_monitor_en_o;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int n_mismatch = 0, comparisons = 0;
  tbps_sequencer #(.SS_CYCLES(SS)) u_dut (.sys_clk_i, .sys_rst_i, .chan1_enable_in_i,
    .chan2_enable_in_i, .chan3_enable_in_i, .bias_level_i, .mode_high_i, .mode_low_i,
    .lockout_rise_i, .lockout_fall_i, .thermal_fault_i, .seq_level1_i, .seq_level2_i,
    .pg_level_i, .in_regulation_i, .chan_run_o, .chan_soft_start_o, .pg_monitor_en_o,
    .internal_bias_rail_o, .seq_ramp_reset_o, .pg_ramp_reset_o, .power_ok_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  tbps_host_model u_host (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .pull_low_i(pull_low),
    .ramp_step_i(ramp), .seq_ramp_reset_i(seq_ramp_reset_o),
    .pg_ramp_reset_i(pg_ramp_reset_o),
    .enable_o({chan3_enable_in_i, chan2_enable_in_i, chan1_enable_in_i}),
    .seq_level1_o(seq_level1_i), .seq_level2_o(seq_level2_i), .pg_level_o(pg_level_i));
  // 125 MHz clock
  always #4 sys_clk_i = ~sys_clk_i;
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // bus master: holds each valid until its ready is sampled
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk_i);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    if (s_axi_bvalid !== 1'b1) n_mismatch++;
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk_i);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (s_axi_rvalid !== 1'b1) n_mismatch++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // counts cycles until soft start of channel two reaches a level
  task automatic till(input logic v, output int n);
    n = 0;
    while (chan_soft_start_o[1] !== v && n < 200) begin
      cyc(1);
      n++;
    end
    if (chan_soft_start_o[1] !== v) n_mismatch++;
  endtask
  // records the order in which channels switch, one nibble each
  task automatic rec(input logic on, output logic [11:0] ord);
    logic [2:0] prev;
    int n;
    prev = chan_run_o;
    ord = 12'h000;
    n = 0;
    while (chan_run_o !== {3{on}} && n < 300) begin
      cyc(1);
      n++;
      for (int i = 0; i < 3; i++)
        if (chan_run_o[i] !== prev[i]) ord = {ord[7:0], 4'(i + 1)};
      prev = chan_run_o;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`TBPS_REG_CTRL, d, r);
    chk(d, `TBPS_CTRL_RST);
    axi_wr(`TBPS_REG_CTRL, 32'h0, r);
    axi_rd(`TBPS_REG_CTRL, d, r);
    chk(d, 32'h0);
    axi_wr(`TBPS_REG_PINS, 32'hFFFFFFFF, r);
    chk(r, `TBPS_RESP_OKAY);
    axi_wr(12'hFFC, 32'h1, r);
    chk(r, `TBPS_RESP_SLVERR);
    axi_rd(12'hFFC, d, r);
    chk(r, `TBPS_RESP_SLVERR);
    chk(d, 32'h0);
    axi_wr(`TBPS_REG_CTRL, 32'h1, r);
    $display("test regs done");
  endtask
  task automatic t_float;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    cyc(6);
    chk(internal_bias_rail_o, 0);
    bias_level_i <= 3'h2;
    cyc(6);
    chk(internal_bias_rail_o, 1);
    pull_low <= 3'h5;
    till(1, n);
    chk(chan_run_o, 3'h2);
    till(0, n);
    chk(n >= SS && n <= SS + 1, 1);
    cyc(2);
    chk(pg_monitor_en_o, 3'h2);
    chk(power_ok_o, 0);
    pull_low <= 3'h0;
    cyc(SS + 40);
    chk(power_ok_o, 1);
    chk(pg_ramp_reset_o, 0);
    axi_rd(`TBPS_REG_STATUS, d, r);
    chk(d, 32'h0000_81C7);
    chk(r, `TBPS_RESP_OKAY);
    in_regulation_i <= 3'h3;
    cyc(6);
    chk(power_ok_o, 0);
    chk(pg_ramp_reset_o, 1);
    in_regulation_i <= 3'h7;
    thermal_fault_i <= 1;
    cyc(6);
    chk(power_ok_o, 0);
    thermal_fault_i <= 0;
    lockout_rise_i <= 0;
    lockout_fall_i <= 1;
    cyc(6);
    chk(chan_run_o, 3'h0);
    lockout_rise_i <= 1;
    lockout_fall_i <= 0;
    cyc(6);
    chk(chan_run_o, 3'h7);
    pull_low <= 3'h2;
    cyc(6);
    chk(chan_run_o, 3'h5);
    pull_low <= 3'h7;
    cyc(6);
    $display("test float done");
  endtask
  // {mode high, enable1, enable2, power-up order, power-down order}
  logic [26:0] tab [8] = '{{3'b011, 24'h123321}, {3'b001, 24'h213312},
    {3'b010, 24'h231132}, {3'b111, 24'h132231}, {3'b101, 24'h312213},
    {3'b110, 24'h321123}, {3'b000, 24'h0}, {3'b100, 24'h0}};
  task automatic t_auto;
    logic [11:0] ord;
    foreach (tab[k]) begin
      mode_high_i <= tab[k][26];
      mode_low_i <= !tab[k][26];
      ramp <= tab[k][26] ? 8'h10 : 8'h04;
      pull_low <= {1'b1, !tab[k][24], !tab[k][25]};
      cyc(8);
      pull_low[2] <= 1'b0;
      rec(1'b1, ord);
      chk(ord, tab[k][23:12]);
      chk(seq_ramp_reset_o, 1);
      pull_low[2] <= 1'b1;
      rec(1'b0, ord);
      chk(ord, tab[k][11:0]);
    end
    $display("test auto done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    cyc(20000);
    n_mismatch++;
    finish_test();
  end
  initial begin
    cyc(4);
    sys_rst_i <= 0;
    cyc(1);
    t_regs();
    t_float();
    t_auto();
    finish_test();
  end
endmodule // tb_triple_buck_power_sequencer
